// [rtl/audp_core.sv]
// Arithmetic unit: fetch sequencing and timed arithmetic execution
// Summary of operation
// RL1: fetch consecutive words, then execute each
// RL2: add or subtract takes 3.2 us
// RL3: add/subtract on single 24-bit words
// RL4: multiply takes 8.9 to 12.1 us
// RL5: signed multiply gives 46 bits plus sign
// RL6: divide takes 13.7 us
// RL7: double dividend gives quotient and remainder
// RL8: bit 23 is sign and MSB
// RL9: two's complement fixed-point binary arithmetic
// RL10: busy held across execution, fetch after
`timescale 1ns/1ps
`default_nettype none
module audp_core (
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_reset_n,
  // Core memory
  output logic                              o_mem_rd,
  output logic [audp_pkg::ADR_W-1:0]        o_mem_addr,
  input  wire logic                         i_mem_ack,
  input  wire audp_pkg::audp_instr_t        i_mem_data,
  // Status and results
  output logic                              o_busy,
  output logic [audp_pkg::WORD_W-1:0]       o_acc,
  output logic [audp_pkg::WORD_W-1:0]       o_mq,
  output logic                              o_overflow,
  output logic                              o_done
);
  localparam int W = audp_pkg::WORD_W;
  audp_pkg::audp_state_t       state_q;
  logic [audp_pkg::ADR_W-1:0]  pc_q;
  audp_pkg::audp_instr_t       ir_q;
  logic [audp_pkg::CNT_W-1:0]  cnt_q;
  logic [audp_pkg::CNT_W-1:0]  target_q;
  logic [W-1:0]                acc_q;
  logic [W-1:0]                mq_q;
  logic                        ovf_q;
  logic                        md_start;
  logic                        md_done;
  audp_pkg::audp_dword_t       md_res;
  audp_pkg::audp_dword_t       md_keep_q;
  logic                        md_have_q;
  logic [W:0]                  sum;
  logic [W-1:0]                addend;
  logic [4:0]                  ones;
  logic [audp_pkg::CNT_W-1:0]  mpy_len;
  logic                        is_md;
  logic                        fin;

  // RL3 single-length add or subtract
  assign addend = (ir_q.op == audp_pkg::OP_SUB) ? ~ir_q.opnd : ir_q.opnd;
  assign sum = {1'b0, acc_q} + {1'b0, addend}
             + {24'h0, (ir_q.op == audp_pkg::OP_SUB)};
  assign is_md = ir_q.op[1];
  assign md_start = (state_q == audp_pkg::ST_WAIT) && i_mem_ack;

  // RL4 length grows with multiplier one bits, within bounds
  always_comb begin
    ones = 5'h00;
    for (int k = 0; k < W; k++)
      ones = ones + {4'h0, acc_q[k]};
    mpy_len = 9'(audp_pkg::CY_MPY_MIN) + 9'(ones)
            + {5'h00, ones[4:1]} + {6'h00, ones[4:2]};
    if (mpy_len > 9'(audp_pkg::CY_MPY_MAX))
      mpy_len = 9'(audp_pkg::CY_MPY_MAX);
  end

  audp_muldiv u_muldiv (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_start   (md_start && i_mem_data.op[1]),
    // Mode follows the word being taken, not the previous instruction
    .i_div     (md_start ? (i_mem_data.op == audp_pkg::OP_DVD)
                : (ir_q.op == audp_pkg::OP_DVD)),
    .i_hi      (acc_q),
    .i_lo      (i_mem_data.op == audp_pkg::OP_DVD || !md_start
                ? mq_q : acc_q),
    .i_opnd    (i_mem_data.opnd),
    .o_done    (md_done),
    .o_res     (md_res)
  );

  assign fin = (state_q == audp_pkg::ST_EXEC) && (cnt_q == target_q)
             && (!is_md || md_have_q || md_done);

  // RL1 fetch and execute sequencing
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= audp_pkg::ST_FETCH;
    end else begin
      unique case (state_q)
        audp_pkg::ST_FETCH: state_q <= audp_pkg::ST_WAIT;
        audp_pkg::ST_WAIT: begin
          if (i_mem_ack)
            state_q <= audp_pkg::ST_EXEC;
        end
        audp_pkg::ST_EXEC: begin
          if (fin)
            state_q <= audp_pkg::ST_DONE;
        end
        audp_pkg::ST_DONE: state_q <= audp_pkg::ST_FETCH;
      endcase
    end
  end

  // RL1 consecutive addresses
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pc_q <= audp_pkg::PC_RESET;
      ir_q <= '0;
    end else if (md_start || (state_q == audp_pkg::ST_WAIT && i_mem_ack)) begin
      ir_q <= i_mem_data;
      pc_q <= pc_q + 15'h0001;
    end
  end

  // RL2 RL4 RL6 execution timing
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q    <= 9'h000;
      target_q <= 9'h000;
    end else if (state_q == audp_pkg::ST_WAIT) begin
      cnt_q <= 9'h002;
      unique case (i_mem_data.op)
        audp_pkg::OP_ADD, audp_pkg::OP_SUB:
          target_q <= 9'(audp_pkg::CY_ADD);
        audp_pkg::OP_MPY: target_q <= mpy_len;
        audp_pkg::OP_DVD: target_q <= 9'(audp_pkg::CY_DVD);
      endcase
    end else if (state_q == audp_pkg::ST_EXEC && cnt_q != target_q) begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      md_have_q <= 1'b0;
      md_keep_q <= '0;
    end else if (md_start) begin
      md_have_q <= 1'b0;
    end else if (md_done) begin
      md_have_q <= 1'b1;
      md_keep_q <= md_res;
    end
  end

  // RL8 RL9 result write-back, sign in bit 23
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_q <= 24'h0;
      mq_q  <= 24'h0;
      ovf_q <= 1'b0;
    end else if (fin) begin
      if (!is_md) begin
        acc_q <= sum[W-1:0];
        ovf_q <= (acc_q[W-1] == addend[W-1]) && (sum[W-1] != acc_q[W-1]);
      end else begin
        acc_q <= md_have_q ? md_keep_q.hi : md_res.hi;
        mq_q  <= md_have_q ? md_keep_q.lo : md_res.lo;
        ovf_q <= 1'b0;
      end
    end
  end

  // RL10 busy until result is complete
  assign o_busy = (state_q == audp_pkg::ST_EXEC);
  assign o_mem_rd = (state_q == audp_pkg::ST_WAIT);
  assign o_mem_addr = pc_q;
  assign o_acc = acc_q;
  assign o_mq = mq_q;
  assign o_overflow = ovf_q;
  assign o_done = (state_q == audp_pkg::ST_DONE);

  // Assertions
  logic [audp_pkg::CNT_W-1:0] busy_len_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      busy_len_q <= 9'h000;
    else if (o_busy)
      busy_len_q <= busy_len_q + 9'h001;
    else
      busy_len_q <= 9'h000;
  end

  AST_ADD_TIME: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL2
    ($fell(o_busy) && !is_md) |-> busy_len_q == 9'(audp_pkg::CY_ADD - 1))
    else $error("add time wrong");
  AST_MPY_TIME: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL4
    ($fell(o_busy) && ir_q.op == audp_pkg::OP_MPY) |->
    (busy_len_q >= 9'(audp_pkg::CY_MPY_MIN - 1)
     && busy_len_q <= 9'(audp_pkg::CY_MPY_MAX - 1)))
    else $error("multiply time out of range");
  AST_DVD_TIME: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL6
    ($fell(o_busy) && ir_q.op == audp_pkg::OP_DVD) |->
    busy_len_q == 9'(audp_pkg::CY_DVD - 1))
    else $error("divide time wrong");
  AST_FETCH_SEQ: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL1
    (o_mem_rd && i_mem_ack) |=> o_mem_addr == $past(o_mem_addr) + 15'h0001)
    else $error("fetch address not consecutive");
  AST_NO_FETCH_BUSY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL10
    o_busy |-> !o_mem_rd)
    else $error("fetch while busy");
  AST_DONE_AFTER: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL10
    $fell(o_busy) |-> o_done ##2 o_mem_rd ##0 !o_busy)
    else $error("no done after busy");
  AST_ADD_RES: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL3
    (fin && ir_q.op == audp_pkg::OP_ADD) |=>
    o_acc == 24'($past(acc_q) + $past(ir_q.opnd)))
    else $error("sum wrong");
  AST_SUB_RES: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL9
    (fin && ir_q.op == audp_pkg::OP_SUB) |=>
    o_acc == 24'($past(acc_q) - $past(ir_q.opnd)))
    else $error("difference wrong");
  AST_OVF_SIGN: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL8
    (fin && !is_md) |=> o_overflow == ((o_acc[W-1] ^ $past(acc_q[W-1]))
      & ~($past(acc_q[W-1]) ^ $past(ir_q.opnd[W-1]) ^ $past(ir_q.op[0]))))
    else $error("overflow flag wrong");
  AST_MUL_RES: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL5
    (fin && ir_q.op == audp_pkg::OP_MPY) |=>
    {o_acc, o_mq} == 48'($signed($past(acc_q))
                         * $signed($past(ir_q.opnd))))
    else $error("product wrong");
  AST_DIV_DONE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL7
    (md_start && i_mem_data.op == audp_pkg::OP_DVD) |-> ##[20:30] md_have_q)
    else $error("divide engine late");
  AST_DIV_RES: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL7
    (fin && ir_q.op == audp_pkg::OP_DVD) |=>
    {$past(acc_q), $past(mq_q)} == 48'($signed(o_mq)
      * $signed($past(ir_q.opnd)) + $signed(o_acc)))
    else $error("quotient and remainder inconsistent");
endmodule : audp_core
`default_nettype wire

// [rtl/audp_muldiv.sv]
// Sequential signed multiply and divide engine, one step per cycle
`timescale 1ns/1ps
`default_nettype none
module audp_muldiv (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  // Request
  input  wire logic                       i_start,
  input  wire logic                       i_div,
  input  wire logic [audp_pkg::WORD_W-1:0] i_hi,
  input  wire logic [audp_pkg::WORD_W-1:0] i_lo,
  input  wire logic [audp_pkg::WORD_W-1:0] i_opnd,
  // Result
  output logic                            o_done,
  output audp_pkg::audp_dword_t           o_res
);
  localparam int W = audp_pkg::WORD_W;
  logic [4:0]       step_q;
  logic             run_q;
  logic [2*W-1:0]   acc_q;
  logic [W-1:0]     mag_q;
  logic             neg_q;
  logic             rneg_q;
  logic [W:0]       trial;
  logic [2*W-1:0]   acc_d;
  logic [2*W-1:0]   dmag;
  logic [W-1:0]     qmag;
  logic [W-1:0]     rmag;
  // RL9 two's complement magnitudes
  assign dmag = i_hi[W-1] ? (~{i_hi, i_lo} + 48'h1) : {i_hi, i_lo};
  assign trial = acc_q[2*W-1:W-1] - {1'b0, mag_q};
  // Results come from the step being taken, so the last bit is not lost
  assign qmag = acc_d[W-1:0];
  assign rmag = acc_d[2*W-1:W];

  always_comb begin
    acc_d = acc_q;
    if (i_div) begin
      // RL7 restoring divide step, shift then trial subtract
      if (acc_q[2*W-1] || !trial[W])
        acc_d = {trial[W-1:0], acc_q[W-2:0], 1'b1};
      else
        acc_d = {acc_q[2*W-2:0], 1'b0};
    end else begin
      // RL5 shift-add multiply step
      acc_d = {(acc_q[0] ? {1'b0, acc_q[2*W-1:W]} + {1'b0, mag_q}
                         : {1'b0, acc_q[2*W-1:W]}), acc_q[W-1:1]};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_q  <= 1'b0;
      step_q <= 5'h00;
      acc_q  <= 48'h0;
      mag_q  <= 24'h0;
      neg_q  <= 1'b0;
      rneg_q <= 1'b0;
      o_done <= 1'b0;
      o_res  <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        run_q  <= 1'b1;
        step_q <= 5'h00;
        mag_q  <= i_opnd[W-1] ? (~i_opnd + 24'h1) : i_opnd;
        if (i_div) begin
          acc_q  <= dmag;
          neg_q  <= i_hi[W-1] ^ i_opnd[W-1];
          rneg_q <= i_hi[W-1];
        end else begin
          acc_q  <= {24'h0, (i_lo[W-1] ? (~i_lo + 24'h1) : i_lo)};
          neg_q  <= i_lo[W-1] ^ i_opnd[W-1];
          rneg_q <= 1'b0;
        end
      end else if (run_q) begin
        step_q <= step_q + 5'h01;
        acc_q  <= acc_d;
        if (step_q == 5'(W - 1)) begin
          run_q  <= 1'b0;
          o_done <= 1'b1;
          if (i_div) begin
            o_res.lo <= neg_q ? (~qmag + 24'h1) : qmag;
            o_res.hi <= rneg_q ? (~rmag + 24'h1) : rmag;
          end else begin
            o_res <= neg_q ? (~acc_d + 48'h1) : acc_d;
          end
        end
      end
    end
  end
endmodule : audp_muldiv
`default_nettype wire

// [rtl/audp_pkg.sv]
// Shared constants and types for the arithmetic unit datapath
package audp_pkg;
  localparam int WORD_W = 24;
  localparam int OP_W   = 2;
  localparam int ADR_W  = 15;
  localparam int CLK_MHZ_X10 = 200;
  // Execution times in tenths of a microsecond
  localparam int T_ADD_US_X10 = 32;
  localparam int T_MPY_MIN_US_X10 = 89;
  localparam int T_MPY_MAX_US_X10 = 121;
  localparam int T_DVD_US_X10 = 137;
  // Cycle counts at 20 MHz: tenths of us times 2
  localparam int CY_ADD = T_ADD_US_X10 * CLK_MHZ_X10 / 100;
  localparam int CY_MPY_MIN = T_MPY_MIN_US_X10 * CLK_MHZ_X10 / 100;
  localparam int CY_MPY_MAX = T_MPY_MAX_US_X10 * CLK_MHZ_X10 / 100;
  localparam int CY_DVD = T_DVD_US_X10 * CLK_MHZ_X10 / 100;
  localparam int CNT_W = 9;
  localparam logic [OP_W-1:0] OP_ADD = 2'h0;
  localparam logic [OP_W-1:0] OP_SUB = 2'h1;
  localparam logic [OP_W-1:0] OP_MPY = 2'h2;
  localparam logic [OP_W-1:0] OP_DVD = 2'h3;
  localparam logic [ADR_W-1:0] PC_RESET = 15'h0000;
  typedef struct packed {
    logic [OP_W-1:0]   op;
    logic [WORD_W-1:0] opnd;
  } audp_instr_t;
  typedef struct packed {
    logic [WORD_W-1:0] hi;
    logic [WORD_W-1:0] lo;
  } audp_dword_t;
  typedef enum logic [3:0] {
    ST_FETCH = 4'h1,
    ST_WAIT  = 4'h2,
    ST_EXEC  = 4'h4,
    ST_DONE  = 4'h8
  } audp_state_t;
endpackage : audp_pkg

// [verif/audp_mem_model.sv]
// Core memory model that answers fetches after a random wait
`timescale 1ns/1ps
`default_nettype none
module audp_mem_model (
  // Clock
  input  wire logic                        i_clk,
  // Fetch port
  input  wire logic                        i_rd,
  input  wire logic [audp_pkg::ADR_W-1:0]  i_addr,
  output logic                             o_ack,
  output audp_pkg::audp_instr_t            o_data
);
  audp_pkg::audp_instr_t prog [0:63];
  integer                seed = 32'hFFBE;
  int                    wait_q = 0;
  initial begin
    o_ack = 1'b0;
    o_data = '0;
  end
  // words served from the requested address
  always @(negedge i_clk) begin
    if (i_rd && wait_q == 0) begin
      o_ack  <= 1'b1;
      o_data <= prog[i_addr[5:0]];
    end else begin
      o_ack  <= 1'b0;
      // Inverted data so a stale word is never mistaken for a fresh one
      o_data <= ~o_data;
    end
    if (!i_rd)
      wait_q <= ($random(seed) & 32'h3) % 3;
    else if (wait_q > 0)
      wait_q <= wait_q - 1;
  end
endmodule : audp_mem_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the arithmetic unit against a memory model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int N = 40;
  logic                          i_clk = 1'b0;
  logic                          i_reset_n = 1'b0;
  logic                          mem_rd, mem_ack, busy, ovf, done;
  logic [audp_pkg::ADR_W-1:0]    mem_addr;
  audp_pkg::audp_instr_t         mem_data;
  logic [23:0]                   acc, mq, m_acc = '0, m_mq = '0, v;
  logic                          m_ov = 1'b0;
  logic [23:0]                   e_acc [0:N-1];
  logic [23:0]                   e_mq [0:N-1];
  logic                          e_ov [0:N-1];
  logic [1:0]                    e_op [0:N-1];
  logic [1:0]                    op;
  int failures = 0, compares = 0, k = 0, cyc = 0, t0 = 0, nt = 0, nd = 0;
  integer seed = 32'hFFBE;

  initial begin
    forever #25 i_clk = ~i_clk;
  end

  audp_mem_model mem (.i_clk(i_clk), .i_rd(mem_rd), .i_addr(mem_addr),
                      .o_ack(mem_ack), .o_data(mem_data));
  audp_core uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .o_mem_rd(mem_rd),
                 .o_mem_addr(mem_addr), .i_mem_ack(mem_ack),
                 .i_mem_data(mem_data), .o_busy(busy), .o_acc(acc),
                 .o_mq(mq), .o_overflow(ovf), .o_done(done));

  task automatic bad(input logic [47:0] g, input logic [47:0] w);
    $display("unexpected at %0t: got %h want %h", $time, g, w);
    failures++;
  endtask : bad
  task automatic chk_word(input logic [23:0] g, input logic [23:0] w);
    compares++;
    if (g !== w) bad(48'(g), 48'(w));
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic w);
    compares++;
    if (g !== w) bad(48'(g), 48'(w));
  endtask : chk_bit
  task automatic chk_time(input int g, input int lo, input int hi);
    compares++;
    if (g < lo || g > hi) bad(48'(g), 48'(lo));
  endtask : chk_time

  // Reference step: two's complement result of one instruction
  task automatic put(input logic [1:0] o_in, input logic [23:0] d);
    logic signed [47:0] a, b, dd, q;
    logic [47:0]        r;
    logic [24:0]        s;
    logic [1:0]         o;
    o = o_in;
    a = {{24{m_acc[23]}}, m_acc};
    b = {{24{d[23]}}, d};
    dd = {m_acc, m_mq};
    q = (b == 48'sh0) ? 48'sh0 : dd / b;
    // Keep the quotient within 23 bits plus sign
    if (o == audp_pkg::OP_DVD && (b == 48'sh0 || q > 48'sh7FFFFF ||
        q < -48'sh7FFFFF))
      o = audp_pkg::OP_ADD;
    if (o == audp_pkg::OP_ADD || o == audp_pkg::OP_SUB) begin
      s = (o == audp_pkg::OP_ADD) ? a[24:0] + b[24:0] : a[24:0] - b[24:0];
      m_ov = s[24] ^ s[23];
      m_acc = s[23:0];
    end else if (o == audp_pkg::OP_MPY) begin
      q = a * b;
      {m_acc, m_mq} = q;
      m_ov = 1'b0;
    end else begin
      r = dd % b;
      m_ov = 1'b0;
      m_mq = q[23:0];
      m_acc = r[23:0];
    end
    mem.prog[k] = {o, d};
    e_op[k] = o;
    e_acc[k] = m_acc;
    e_mq[k] = m_mq;
    e_ov[k] = m_ov;
    k++;
  endtask : put

  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  always @(posedge i_clk) begin
    if (i_reset_n && nd < N) begin
      cyc++;
      if (busy) chk_bit(mem_rd, 1'b0);
      if (mem_rd && mem_ack) begin
        chk_word(24'(mem_addr), 24'(nt));
        t0 = cyc;
        nt++;
      end
      if (done) begin
        if (e_op[nd] == audp_pkg::OP_MPY)
          chk_time(cyc - t0, 178, 242);
        else if (e_op[nd] == audp_pkg::OP_DVD)
          chk_time(cyc - t0, 274, 274);
        else
          chk_time(cyc - t0, 64, 64);
        chk_bit(busy, 1'b0);
        chk_word(acc, e_acc[nd]);
        chk_word(mq, e_mq[nd]);
        chk_bit(ovf, e_ov[nd]);
        nd++;
      end
    end
  end

  initial begin
    // Overflow both ways, multiply with 7FFFFF in the accumulator, signed divides
    put(audp_pkg::OP_ADD, 24'h7FFFFF);
    put(audp_pkg::OP_ADD, 24'h000001);
    put(audp_pkg::OP_SUB, 24'h000001);
    put(audp_pkg::OP_MPY, 24'h800000);
    put(audp_pkg::OP_SUB, m_acc);
    put(audp_pkg::OP_DVD, 24'h000003);
    put(audp_pkg::OP_SUB, m_acc);
    put(audp_pkg::OP_MPY, 24'h000005);
    put(audp_pkg::OP_ADD, 24'hFFFFFF);
    put(audp_pkg::OP_DVD, 24'h800000);
    while (k < N) begin
      op = 2'($random(seed));
      v = 24'($random(seed));
      if (op == audp_pkg::OP_DVD && k < N - 1)
        put(audp_pkg::OP_SUB, m_acc);
      put(op, v);
    end
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_reset_n = 1'b1;
    for (int w = 0; w < 20000 && nd < N; w++)
      @(posedge i_clk);
    if (nd < N)
      failures++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
